// file: src/atc_pkg.sv
// package for the analog torque command conditioning block
package atc_pkg;
  // register byte offsets on the wishbone slave
  localparam logic [7:0] ADDR_DEADBAND = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_TORQUE_GAIN = 8'h08;
  localparam logic [7:0] ADDR_VEL_GAIN = 8'h0c;
  localparam logic [7:0] ADDR_RIPPLE = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  localparam logic [7:0] ADDR_CMD_OUT = 8'h1c;
  // mode register field positions
  localparam int MODE_TYPE_BIT = 0;
  localparam int MODE_FA1_LSB = 4;
  localparam int MODE_OUTFN_LSB = 8;
  localparam int MODE_GPO_BIT = 12;
  // reset values
  localparam logic [7:0] DEADBAND_RST = 8'h00;
  localparam logic TYPE_RST = 1'b0;
  localparam logic [1:0] FA1_RST = 2'h3;
  localparam logic [3:0] OUTFN_RST = 4'h3;
  localparam logic signed [15:0] TORQUE_GAIN_RST = 16'sh0064;
  localparam logic signed [15:0] VEL_GAIN_RST = 16'sh03e8;
  localparam logic [8:0] RIPPLE_RST = 9'h000;
  // setting limits, in display units (x100 for amps and rps)
  localparam logic [1:0] FA1_VEL_LIMIT = 2'h1;
  localparam logic [1:0] FA1_MAX = 2'h3;
  localparam logic [3:0] OUTFN_TRQ_LOW = 4'h9;
  localparam logic [3:0] OUTFN_TRQ_HIGH = 4'h8;
  localparam logic signed [15:0] TORQUE_GAIN_MAX = 16'sh07d0;
  localparam logic signed [15:0] VEL_GAIN_MAX = 16'sh2710;
  localparam logic [8:0] RIPPLE_MAX = 9'h12c;
  // full scale input (10 V) in mV
  localparam logic signed [15:0] FULL_SCALE_MV = 16'sh2710;
  // status bits
  localparam int ST_REACHED = 0;
  localparam int ST_LOST = 1;
  localparam int ST_LIMIT = 2;

  typedef struct packed {
    logic [7:0] se_deadband;
    logic [7:0] diff_deadband;
    logic type_sel;
    logic [1:0] fa1_sel;
    logic [3:0] outfn;
    logic gpo;
    logic signed [15:0] torque_gain;
    logic signed [15:0] vel_gain;
    logic [8:0] ripple;
    logic [2:0] irq_mask;
  } atc_cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_DONE = 2'b11
  } atc_bus_t;

  typedef struct packed {
    atc_cfg_t cfg;
    atc_bus_t bus;
    logic [31:0] dat;
    logic signed [15:0] cmd_ma;
    logic signed [15:0] vlim;
    logic reached;
    logic limiting;
    logic [2:0] status;
    logic out3;
  } atc_state_t;
endpackage

// file: src/atc_torque_cond.sv
// analog torque command conditioning with wishbone register access
`timescale 1ns/1ps
module atc_torque_cond (
  input wire logic CLK, // system clock, 100 MHz
  input wire logic RESET, // asynchronous reset, active high
  input wire logic [31:0] WB_ADR_I, // wishbone byte address
  input wire logic [31:0] WB_DAT_I, // wishbone write data
  output logic [31:0] WB_DAT_O, // wishbone read data
  input wire logic WB_WE_I, // wishbone write enable
  input wire logic [3:0] WB_SEL_I, // wishbone byte selects
  input wire logic WB_CYC_I, // wishbone cycle
  input wire logic WB_STB_I, // wishbone strobe
  output logic WB_ACK_O, // wishbone acknowledge
  input wire logic signed [15:0] FIRST_ANALOG_IN, // first analog input, mV
  input wire logic signed [15:0] SECOND_ANALOG_IN, // second analog input, mV
  input wire logic RUN_STOP_SWITCH_IN, // high when run switch closed
  input wire logic DIRECTION_SWITCH_IN, // high when direction switch closed
  input wire logic signed [15:0] ACTUAL_TORQUE_MA, // measured motor current, 0.01 A
  input wire logic signed [15:0] MOTOR_SPEED, // measured speed, 0.01 rps
  output logic signed [15:0] TORQUE_CMD, // conditioned torque command, 0.01 A
  output logic TORQUE_REACHED_OUT, // third digital output, high = closed
  output logic IRQ // level interrupt
);

  atc_pkg::atc_state_t s_r;
  atc_pkg::atc_state_t s_nxt;

  logic [7:0] offs;
  logic hit;
  logic signed [16:0] ana;
  logic [7:0] dband;
  logic signed [16:0] cond;
  logic signed [31:0] trq;
  logic signed [31:0] lim;
  logic signed [16:0] err;
  logic [16:0] err_abs;
  logic [16:0] spd_abs;
  logic in_win;
  logic [2:0] events;
  logic [31:0] wr_base;
  logic [31:0] wr_word;

  function automatic logic signed [15:0] clamp16(input logic signed [31:0] v, input logic signed [15:0] mx);
    logic signed [31:0] m;
    m = 32'(mx);
    if (v > m)
      clamp16 = mx;
    else if (v < -m)
      clamp16 = -mx;
    else
      clamp16 = v[15:0];
  endfunction

  // strip the deadband and shift the remainder toward zero so there is no step at its edge
  function automatic logic signed [16:0] deadband(input logic signed [16:0] v, input logic [7:0] db);
    logic signed [16:0] d;
    d = {9'h000, db};
    if (v > d)
      deadband = v - d;
    else if (v < -d)
      deadband = v + d;
    else
      deadband = 17'sh00000;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i])
        r[i*8 +: 8] = wd[i*8 +: 8];
    end
    merge = r;
  endfunction

  function automatic logic [31:0] mode_word(input atc_pkg::atc_cfg_t c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[atc_pkg::MODE_TYPE_BIT] = c.type_sel;
    w[atc_pkg::MODE_FA1_LSB +: 2] = c.fa1_sel;
    w[atc_pkg::MODE_OUTFN_LSB +: 4] = c.outfn;
    w[atc_pkg::MODE_GPO_BIT] = c.gpo;
    mode_word = w;
  endfunction

  assign offs = WB_ADR_I[7:0];
  assign hit = (WB_ADR_I[31:8] == 24'h000000) && (offs[1:0] == 2'b00);

  // current contents of the addressed register merged with the write data, so byte selects keep untouched bytes
  always_comb begin
    case (offs)
      atc_pkg::ADDR_DEADBAND: wr_base = {16'h0000, s_r.cfg.diff_deadband, s_r.cfg.se_deadband};
      atc_pkg::ADDR_MODE: wr_base = mode_word(s_r.cfg);
      atc_pkg::ADDR_TORQUE_GAIN: wr_base = 32'(s_r.cfg.torque_gain);
      atc_pkg::ADDR_VEL_GAIN: wr_base = 32'(s_r.cfg.vel_gain);
      atc_pkg::ADDR_RIPPLE: wr_base = {23'h0, s_r.cfg.ripple};
      atc_pkg::ADDR_IRQ_MASK: wr_base = {29'h0, s_r.cfg.irq_mask};
      default: wr_base = 32'h0000_0000;
    endcase
    wr_word = merge(wr_base, WB_DAT_I, WB_SEL_I);
  end

  // input selection and deadband
  always_comb begin
    if (s_r.cfg.type_sel) begin
      ana = 17'(SECOND_ANALOG_IN) - 17'(FIRST_ANALOG_IN);
      dband = s_r.cfg.diff_deadband;
    end else begin
      ana = 17'(SECOND_ANALOG_IN);
      dband = s_r.cfg.se_deadband;
    end
    cond = deadband(ana, dband);
  end

  // command scaling and reached window
  always_comb begin
    trq = (32'(cond) * 32'(s_r.cfg.torque_gain)) / 32'(atc_pkg::FULL_SCALE_MV);
    if (DIRECTION_SWITCH_IN)
      trq = -trq;
    // limit from first input; gain kept as rps x100
    lim = (32'(FIRST_ANALOG_IN) * 32'(s_r.cfg.vel_gain)) / 32'(atc_pkg::FULL_SCALE_MV);
    if (lim < 0)
      lim = -lim;
    err = 17'(ACTUAL_TORQUE_MA) - 17'(s_r.cmd_ma);
    err_abs = err[16] ? 17'(-err) : 17'(err);
    spd_abs = MOTOR_SPEED[15] ? 17'(-17'(MOTOR_SPEED)) : 17'(MOTOR_SPEED);
    in_win = err_abs <= {8'h00, s_r.cfg.ripple};
  end

  always_comb begin
    s_nxt = s_r;
    events = 3'b000;
    WB_DAT_O = s_r.dat;
    WB_ACK_O = (s_r.bus == atc_pkg::ST_DONE);

    // command path; open switch forces zero regardless of input
    if (!RUN_STOP_SWITCH_IN)
      s_nxt.cmd_ma = 16'sh0000;
    else
      s_nxt.cmd_ma = clamp16(trq, 16'sh7fff);
    s_nxt.limiting = 1'b0;
    if (RUN_STOP_SWITCH_IN && s_r.cfg.fa1_sel == atc_pkg::FA1_VEL_LIMIT && 32'(spd_abs) > lim) begin
      // overspeed halves the command each cycle it persists; crude but cannot oscillate
      s_nxt.cmd_ma = s_r.cmd_ma >>> 1;
      s_nxt.limiting = 1'b1;
    end

    s_nxt.reached = RUN_STOP_SWITCH_IN && in_win;
    case (s_r.cfg.outfn)
      atc_pkg::OUTFN_TRQ_LOW: s_nxt.out3 = !s_nxt.reached;
      atc_pkg::OUTFN_TRQ_HIGH: s_nxt.out3 = s_nxt.reached;
      default: s_nxt.out3 = s_r.cfg.gpo;
    endcase

    events[atc_pkg::ST_REACHED] = s_nxt.reached && !s_r.reached;
    events[atc_pkg::ST_LOST] = !s_nxt.reached && s_r.reached;
    events[atc_pkg::ST_LIMIT] = s_nxt.limiting && !s_r.limiting;

    // wishbone slave: two wait states, ack for one cycle
    case (s_r.bus)
      atc_pkg::ST_IDLE: begin
        if (WB_CYC_I && WB_STB_I)
          s_nxt.bus = atc_pkg::ST_RUN;
      end
      atc_pkg::ST_RUN: begin
        s_nxt.bus = atc_pkg::ST_DONE;
        s_nxt.dat = 32'h0000_0000;
        if (hit && WB_WE_I) begin
          case (offs)
            atc_pkg::ADDR_DEADBAND: begin
              s_nxt.cfg.se_deadband = wr_word[7:0];
              s_nxt.cfg.diff_deadband = wr_word[15:8];
            end
            atc_pkg::ADDR_MODE: begin
              s_nxt.cfg.type_sel = wr_word[atc_pkg::MODE_TYPE_BIT];
              s_nxt.cfg.gpo = wr_word[atc_pkg::MODE_GPO_BIT];
              s_nxt.cfg.outfn = wr_word[atc_pkg::MODE_OUTFN_LSB +: 4];
              // a zero function code keeps the old setting
              if (wr_word[atc_pkg::MODE_FA1_LSB +: 2] != 2'h0)
                s_nxt.cfg.fa1_sel = wr_word[atc_pkg::MODE_FA1_LSB +: 2];
            end
            atc_pkg::ADDR_TORQUE_GAIN:
              s_nxt.cfg.torque_gain = clamp16(32'(signed'(wr_word[15:0])), atc_pkg::TORQUE_GAIN_MAX);
            atc_pkg::ADDR_VEL_GAIN:
              s_nxt.cfg.vel_gain = clamp16(32'(signed'(wr_word[15:0])), atc_pkg::VEL_GAIN_MAX);
            atc_pkg::ADDR_RIPPLE: begin
              if (wr_word[15:0] > 16'(atc_pkg::RIPPLE_MAX))
                s_nxt.cfg.ripple = atc_pkg::RIPPLE_MAX;
              else
                s_nxt.cfg.ripple = wr_word[8:0];
            end
            atc_pkg::ADDR_IRQ_MASK:
              s_nxt.cfg.irq_mask = wr_word[2:0];
            default: ;
          endcase
        end else if (hit) begin
          case (offs)
            atc_pkg::ADDR_DEADBAND: s_nxt.dat = {16'h0000, s_r.cfg.diff_deadband, s_r.cfg.se_deadband};
            atc_pkg::ADDR_MODE: s_nxt.dat = mode_word(s_r.cfg);
            atc_pkg::ADDR_TORQUE_GAIN: s_nxt.dat = 32'(s_r.cfg.torque_gain);
            atc_pkg::ADDR_VEL_GAIN: s_nxt.dat = 32'(s_r.cfg.vel_gain);
            atc_pkg::ADDR_RIPPLE: s_nxt.dat = {23'h0, s_r.cfg.ripple};
            atc_pkg::ADDR_STATUS: s_nxt.dat = {29'h0, s_r.status};
            atc_pkg::ADDR_IRQ_MASK: s_nxt.dat = {29'h0, s_r.cfg.irq_mask};
            atc_pkg::ADDR_CMD_OUT: s_nxt.dat = {s_r.out3, 15'h0000, s_r.cmd_ma};
            default: s_nxt.dat = 32'h0000_0000;
          endcase
          if (offs == atc_pkg::ADDR_STATUS)
            s_nxt.status = 3'b000; // read clears
        end
      end
      atc_pkg::ST_DONE: s_nxt.bus = atc_pkg::ST_IDLE;
      default: s_nxt.bus = atc_pkg::ST_IDLE;
    endcase
    // set wins over the read clear
    s_nxt.status = s_nxt.status | events;
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      s_r <= '0;
      s_r.cfg.se_deadband <= atc_pkg::DEADBAND_RST;
      s_r.cfg.diff_deadband <= atc_pkg::DEADBAND_RST;
      s_r.cfg.type_sel <= atc_pkg::TYPE_RST;
      s_r.cfg.fa1_sel <= atc_pkg::FA1_RST;
      s_r.cfg.outfn <= atc_pkg::OUTFN_RST;
      s_r.cfg.torque_gain <= atc_pkg::TORQUE_GAIN_RST;
      s_r.cfg.vel_gain <= atc_pkg::VEL_GAIN_RST;
      s_r.cfg.ripple <= atc_pkg::RIPPLE_RST;
      s_r.bus <= atc_pkg::ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign TORQUE_CMD = s_r.cmd_ma;
  assign TORQUE_REACHED_OUT = s_r.out3;
  assign IRQ = |(s_r.status & s_r.cfg.irq_mask);

endmodule // atc_torque_cond

// file: test/atc_asserts.sv
// port-level assertions for the torque conditioning block
`timescale 1ns/1ps
module atc_asserts (
  input wire logic CLK, // clock
  input wire logic RESET, // async reset
  input wire logic [31:0] WB_ADR_I, // address
  input wire logic [31:0] WB_DAT_O, // read data
  input wire logic WB_WE_I, // write
  input wire logic WB_CYC_I, // cycle
  input wire logic WB_STB_I, // strobe
  input wire logic WB_ACK_O, // acknowledge
  input wire logic signed [15:0] FIRST_ANALOG_IN, // first input
  input wire logic signed [15:0] SECOND_ANALOG_IN, // second input
  input wire logic RUN_STOP_SWITCH_IN, // run
  input wire logic DIRECTION_SWITCH_IN, // direction
  input wire logic signed [15:0] MOTOR_SPEED, // speed
  input wire logic signed [15:0] TORQUE_CMD, // command
  input wire logic TORQUE_REACHED_OUT, // third output
  input wire logic IRQ // interrupt
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  wire logic req = WB_CYC_I && WB_STB_I;
  wire logic run = RUN_STOP_SWITCH_IN;
  ack_one_cycle_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held too long");
  ack_in_time_a: assert property ($rose(req) |-> ##[1:3] WB_ACK_O) else $error("ack late");
  ack_needs_req_a: assert property (WB_ACK_O |-> req) else $error("ack without request");
  unmapped_zero_a: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I[31:8] != 0 |-> WB_DAT_O == 0)
    else $error("unmapped read not zero");
  stop_zero_a: assert property (!run |=> TORQUE_CMD == 0) else $error("command while stopped");
  zero_in_a: assert property (run && FIRST_ANALOG_IN == 0 && SECOND_ANALOG_IN == 0 && MOTOR_SPEED == 0
    |=> TORQUE_CMD == 0) else $error("command from zero input");
  dir_flip_a: assert property (run && $past(run) && !$past(RESET) && $changed(DIRECTION_SWITCH_IN)
    && $stable(FIRST_ANALOG_IN) && $stable(SECOND_ANALOG_IN) && MOTOR_SPEED == 0 && $past(MOTOR_SPEED) == 0
    && !WB_CYC_I && !$past(WB_CYC_I) |=> TORQUE_CMD == -$past(TORQUE_CMD)) else $error("direction not reversed");
  reset_quiet_a: assert property ($fell(RESET) |-> TORQUE_CMD == 0 && !TORQUE_REACHED_OUT && !IRQ)
    else $error("outputs active after reset");
  cmd_readback_a: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I == 32'h1c && $stable(TORQUE_CMD)
    && $past(TORQUE_CMD, 2) == TORQUE_CMD |-> WB_DAT_O[15:0] == TORQUE_CMD) else $error("readback wrong");
  cover property (WB_ACK_O && !WB_WE_I);
  cover property (run && DIRECTION_SWITCH_IN && TORQUE_CMD != 0);
  cover property ($rose(TORQUE_REACHED_OUT));
  cover property ($rose(IRQ));
endmodule // atc_asserts
bind atc_torque_cond atc_asserts u_chk (.CLK(CLK), .RESET(RESET), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O),
  .WB_WE_I(WB_WE_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
  .FIRST_ANALOG_IN(FIRST_ANALOG_IN), .SECOND_ANALOG_IN(SECOND_ANALOG_IN), .RUN_STOP_SWITCH_IN(RUN_STOP_SWITCH_IN),
  .DIRECTION_SWITCH_IN(DIRECTION_SWITCH_IN), .MOTOR_SPEED(MOTOR_SPEED), .TORQUE_CMD(TORQUE_CMD),
  .TORQUE_REACHED_OUT(TORQUE_REACHED_OUT), .IRQ(IRQ));

// file: test/atc_host_model.sv
// host controller model: analog command, switches and motor feedback
`timescale 1ns/1ps
module atc_host_model (
  output logic signed [15:0] first_o, // first analog input, mV
  output logic signed [15:0] second_o, // second analog input, mV
  output logic run_o, // run switch, high = closed
  output logic dir_o, // direction switch, high = closed
  output logic signed [15:0] act_o, // measured torque
  output logic signed [15:0] spd_o // measured speed
);
  initial {first_o, second_o, run_o, dir_o, act_o, spd_o} = '0;
  // caller invokes this just after a rising edge, so levels move off the sampling edge
  task automatic drive(input int f, s, input bit r, d, input int at, sp);
    first_o <= 16'(f);
    second_o <= 16'(s);
    run_o <= r;
    dir_o <= d;
    act_o <= 16'(at);
    spd_o <= 16'(sp);
  endtask
endmodule // atc_host_model

// file: test/atc_torque_cond_bench.sv
// self-checking bench for the torque conditioning block
`timescale 1ns/1ps
module atc_torque_cond_bench;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, irq, out3, run, dir;
  logic [31:0] adr = 0, wd = 0, rd, q;
  logic signed [15:0] a1, a2, act, spd, cmd;
  int fails = 0, n_tests = 0, sdb, ddb, g, f, s, dg;
  bit r, t;
  initial forever #5 clk = ~clk;
  atc_host_model u_host (.first_o(a1), .second_o(a2), .run_o(run), .dir_o(dir), .act_o(act), .spd_o(spd));
  atc_torque_cond u_dut (.CLK(clk), .RESET(rst), .WB_ADR_I(adr), .WB_DAT_I(wd), .WB_DAT_O(rd), .WB_WE_I(we),
    .WB_SEL_I(4'hf), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_ACK_O(ack), .FIRST_ANALOG_IN(a1),
    .SECOND_ANALOG_IN(a2), .RUN_STOP_SWITCH_IN(run), .DIRECTION_SWITCH_IN(dir), .ACTUAL_TORQUE_MA(act),
    .MOTOR_SPEED(spd), .TORQUE_CMD(cmd), .TORQUE_REACHED_OUT(out3), .IRQ(irq));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] sn, e);
    n_tests++;
    if (sn !== e) begin
      fails++;
      $display("FAIL %s exp %h seen %h", nm, e, sn);
    end
  endtask
  // ack is looked at mid-cycle, so the request stands through the rising edge that samples it high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= {24'h0, a};
    wd <= d;
    do begin
      @(negedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rd;
    if (n >= 20) fails++;
    @(posedge clk);
    cyc <= 0;
    stb <= 0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(0, a, 0);
    chk(nm, q, e);
  endtask
  // truncation toward zero, same as the fixed-point scaling it mirrors
  function automatic int exp_cmd(bit dd);
    int x;
    int db;
    x = t ? s - f : s;
    db = t ? ddb : sdb;
    x = x > db ? x - db : (x < -db ? x + db : 0);
    x = x * g / 10000;
    return r ? (dd ? -x : x) : 0;
  endfunction
  initial begin
    #100000;
    fails++;
    report_and_stop;
  end
  initial begin
    void'($urandom(80));
    repeat (4) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rdc(8'h00, 0, "deadbands");
    rdc(8'h04, 32'h330, "mode");
    rdc(8'h08, 32'd100, "torque gain");
    rdc(8'h0c, 32'd1000, "vel gain");
    rdc(8'h10, 0, "ripple");
    rdc(8'h40, 0, "unmapped");
    wb(1, 8'h08, 32'd3000);
    rdc(8'h08, 32'd2000, "torque gain max");
    wb(1, 8'h0c, 32'd20000);
    rdc(8'h0c, 32'd10000, "vel gain max");
    wb(1, 8'h10, 32'd400);
    rdc(8'h10, 32'd300, "ripple max");
    wb(1, 8'h04, 32'h300);
    rdc(8'h04, 32'h330, "function zero");
    for (int i = 0; i < 40; i++) begin
      sdb = $urandom_range(255);
      ddb = $urandom_range(255);
      g = $urandom_range(4000) - 2000;
      f = $urandom_range(10000) - 5000;
      s = $urandom_range(10000) - 5000;
      r = $urandom_range(3) != 0;
      t = i[0];
      wb(1, 8'h00, {16'h0, ddb[7:0], sdb[7:0]});
      wb(1, 8'h08, g);
      wb(1, 8'h04, 32'h330 | t);
      for (int k = 0; k < 2; k++) begin
        u_host.drive(f, s, r, k[0], 0, 0);
        repeat (2) @(posedge clk);
        chk("cmd", 32'(cmd), 32'(exp_cmd(k[0])));
      end
    end
    wb(1, 8'h00, 0);
    wb(1, 8'h08, 32'd100);
    wb(1, 8'h10, 32'd50);
    for (int i = 0; i < 3; i++) begin
      dg = i == 0 ? 8 : (i == 1 ? 9 : 3);
      wb(1, 8'h04, (dg << 8) | 32'h1030);
      wb(1, 8'h18, dg != 3);
      u_host.drive(0, 5000, 1, 0, 300, 0);
      repeat (4) @(posedge clk);
      wb(0, 8'h14, 0);
      chk("out far", out3, dg != 8);
      u_host.drive(0, 5000, 1, 0, 55, 0);
      repeat (4) @(posedge clk);
      chk("out near", out3, dg != 9);
      chk("irq", irq, dg != 3);
      rdc(8'h14, 32'h1, "status");
      chk("irq cleared", irq, 0);
      rdc(8'h1c, {dg != 9, 31'd50}, "cmd out");
    end
    wb(1, 8'h04, 32'h310);
    wb(1, 8'h0c, 32'd1000);
    u_host.drive(1000, 5000, 1, 0, 0, 500);
    repeat (4) @(posedge clk);
    chk("limited", 32'(cmd < 50 && cmd >= 0), 1);
    wb(0, 8'h14, 0);
    chk("limit flag", q[2], 1);
    report_and_stop;
  end
endmodule // atc_torque_cond_bench
